// ### common/adcctl_regs.vh
// register map, field positions, reset values and timing counts of adcctl
`ifndef ADCCTL_REGS_VH
`define ADCCTL_REGS_VH

`define ADCCTL_CONTROL_0_ADDR 12'hF70
`define ADCCTL_STATUS_ADDR 12'hF74
`define ADCCTL_MASK_ADDR 12'hF78
`define ADCCTL_CONTROL_0_RESET 8'h00
`define ADCCTL_STATUS_RESET 2'h0
`define ADCCTL_MASK_RESET 2'h0

`define ADCCTL_CEN_BIT 7
`define ADCCTL_REFSEL_BIT 6
`define ADCCTL_EXTREF_BIT 5
`define ADCCTL_REPEAT_BIT 4
`define ADCCTL_CHAN_MSB 3
`define ADCCTL_CHAN_LSB 0

`define ADCCTL_ST_DONE_BIT 0
`define ADCCTL_ST_RESTART_BIT 1

`define ADCCTL_TEMP_CHANNEL 4'hF

`define ADCCTL_SINGLE_CYCLES 14'h1409
`define ADCCTL_TEMP_SINGLE_CYCLES 14'h2812
`define ADCCTL_REPEAT_CYCLES 14'h0100
`define ADCCTL_TEMP_REPEAT_CYCLES 14'h0200

`endif

// ### core/adcctl_top.v
// adc conversion control with ahb-lite register slave and interrupt
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "adcctl_regs.vh"

module adcctl_top #(
  parameter [13:0] SINGLE_CYCLES = `ADCCTL_SINGLE_CYCLES,
  parameter [13:0] TEMP_SINGLE_CYCLES = `ADCCTL_TEMP_SINGLE_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg conv_start,
  output reg conv_busy,
  output reg conv_done,
  output reg [3:0] input_channel_select,
  output reg reference_select_low,
  output reg external_reference_enable,
  output reg irq
);

  reg [7:0] ctl_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [13:0] cnt_reg;
  reg [13:0] cnt_next;
  reg busy_next;
  reg cen_next;
  reg start_next;
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [11:0] addr_reg;
  reg [31:0] rdata_next;

  wire addr_phase;
  wire wr_ctl;
  wire wr_stat;
  wire wr_mask;
  wire start_req;
  wire done;
  wire [6:0] ctl_low_next;
  wire temp_now;
  wire [13:0] single_len;
  wire [13:0] repeat_len;
  wire repeat_next;
  wire [1:0] status_set;
  wire [1:0] status_next;
  wire [1:0] mask_next;
  wire irq_next;

  // a transfer is taken only while the bus is ready
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_ctl = wr_pend_reg && (addr_reg == `ADCCTL_CONTROL_0_ADDR);
  assign wr_stat = wr_pend_reg && (addr_reg == `ADCCTL_STATUS_ADDR);
  assign wr_mask = wr_pend_reg && (addr_reg == `ADCCTL_MASK_ADDR);
  // a write of zero to the enable bit is simply not a start
  assign start_req = wr_ctl && hwdata[`ADCCTL_CEN_BIT];
  assign done = conv_busy && (cnt_reg == 14'h0001);

  assign ctl_low_next = wr_ctl ? hwdata[6:0] : ctl_reg[6:0];
  assign temp_now = (ctl_low_next[`ADCCTL_CHAN_MSB:`ADCCTL_CHAN_LSB] ==
    `ADCCTL_TEMP_CHANNEL);
  assign single_len = temp_now ? TEMP_SINGLE_CYCLES : SINGLE_CYCLES;
  assign repeat_len = temp_now ? `ADCCTL_TEMP_REPEAT_CYCLES :
    `ADCCTL_REPEAT_CYCLES;
  assign repeat_next = ctl_low_next[`ADCCTL_REPEAT_BIT];

  // event inputs of the sticky status bits
  assign status_set[`ADCCTL_ST_DONE_BIT] = done;
  // a restart on the completion edge counts as completion only
  assign status_set[`ADCCTL_ST_RESTART_BIT] = start_req && conv_busy &&
    !done;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_status
      // set wins over a write-one-to-clear in the same cycle
      assign status_next[i] = status_set[i] ||
        (status_reg[i] && !(wr_stat && hwdata[i]));
    end
  endgenerate

  assign mask_next = wr_mask ? hwdata[1:0] : mask_reg;
  // next values, so irq rises on the edge that sets the status bit
  assign irq_next = |(status_next & mask_next);

  always @* begin
    cen_next = ctl_reg[`ADCCTL_CEN_BIT];
    busy_next = conv_busy;
    cnt_next = cnt_reg;
    start_next = 1'b0;
    if (start_req) begin
      // a start during a conversion throws the old one away
      cen_next = 1'b1;
      busy_next = 1'b1;
      cnt_next = single_len;
      start_next = 1'b1;
    end else if (done) begin
      if (repeat_next) begin
        cnt_next = repeat_len;
        start_next = 1'b1;
      end else begin
        cen_next = 1'b0;
        busy_next = 1'b0;
        cnt_next = 14'h0000;
      end
    end else if (conv_busy) begin
      cnt_next = cnt_reg - 14'h0001;
    end
  end

  always @* begin
    case (addr_reg)
      `ADCCTL_CONTROL_0_ADDR: rdata_next = {24'h000000, ctl_reg};
      `ADCCTL_STATUS_ADDR: rdata_next = {30'h00000000, status_reg};
      `ADCCTL_MASK_ADDR: rdata_next = {30'h00000000, mask_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_reg <= haddr[11:0];
      end
    end
  end

  // one wait state on reads so a write just retired is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(addr_phase && !hwrite);
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      if (rd_pend_reg) begin
        hrdata <= rdata_next;
      end
    end
  end

  // no error response: unmapped words read zero instead
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_reg <= `ADCCTL_CONTROL_0_RESET;
    end else begin
      ctl_reg <= {cen_next, ctl_low_next};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= `ADCCTL_STATUS_RESET;
      mask_reg <= `ADCCTL_MASK_RESET;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 14'h0000;
      conv_busy <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      conv_busy <= busy_next;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_start <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_start <= start_next;
      conv_done <= done;
    end
  end

  // analog side sees the settings on the same edge that the write lands in ctl_reg
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_channel_select <= 4'h0;
      reference_select_low <= 1'b0;
      external_reference_enable <= 1'b0;
    end else begin
      input_channel_select <= ctl_low_next[`ADCCTL_CHAN_MSB:`ADCCTL_CHAN_LSB];
      reference_select_low <= ctl_low_next[`ADCCTL_REFSEL_BIT];
      external_reference_enable <= ctl_low_next[`ADCCTL_EXTREF_BIT];
    end
  end

endmodule // adcctl_top

// ### tb/adcctl_checker.sv
// concurrent checks on the conversion and bus response outputs of adcctl_top
`timescale 1ns/1ns
module adcctl_checker (
  input wire hclk,
  input wire hresetn,
  input wire conv_busy,
  input wire conv_done,
  input wire conv_start,
  input wire hreadyout,
  input wire hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  done_after_busy_a: assert property (conv_done |-> $past(conv_busy))
    else $error("done without busy");
  busy_fall_done_a: assert property ($fell(conv_busy) |-> conv_done)
    else $error("busy fell without done");
  min_length_a: assert property (conv_done |-> $past(conv_busy, 8))
    else $error("conversion too short");
  start_sets_busy_a: assert property (conv_start |-> conv_busy)
    else $error("start without busy");
  busy_rise_start_a: assert property ($rose(conv_busy) |-> conv_start)
    else $error("busy rose without start");
  done_one_cycle_a: assert property (conv_done |=> !conv_done)
    else $error("done longer than one cycle");
  ready_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("more than one wait state");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
endmodule // adcctl_checker
bind adcctl_top adcctl_checker chk (.*);

// ### tb/testbench.sv
// register-level bench for adcctl_top
`timescale 1ns/1ns
module testbench;
  reg hclk = 0, hresetn = 0, hwrite = 0;
  reg [1:0] htrans = 0;
  reg [31:0] haddr = 0, hwdata = 0;
  wire [31:0] hrdata;
  wire hreadyout, conv_busy, conv_done, irq, conv_start, hresp;
  wire reference_select_low, external_reference_enable;
  wire [3:0] input_channel_select;
  wire [5:0] pins = {reference_select_low, external_reference_enable,
    input_channel_select};
  reg [15:0] run_len = 0, last_len = 0, start_count = 0;
  integer bad_count = 0, checks_done = 0, cyc = 0;
  always #2 hclk = ~hclk;
  always @(posedge hclk) if (++cyc == 3000) wrap_up(1);
  adcctl_top #(.SINGLE_CYCLES(14'h0014), .TEMP_SINGLE_CYCLES(14'h0028)) dut (
    .hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .conv_start, .conv_busy, .conv_done, .input_channel_select,
    .reference_select_low, .external_reference_enable, .irq);
  // length of the last finished conversion; a start pulse restarts it
  always @(posedge hclk) begin
    if (conv_start) run_len <= 16'h0001;
    else if (conv_busy) run_len <= run_len + 16'h0001;
    if (conv_done) last_len <= run_len;
    if (conv_start) start_count <= start_count + 16'h0001;
  end
  // one edge more so last_len has taken the finished length
  task wait_done;
    do @(posedge hclk); while (!conv_done);
    @(posedge hclk);
  endtask
  task ck(input [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %h %h", $time, g, e);
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    {hwrite, haddr} <= {w, 20'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (!hreadyout);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (!hreadyout);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    bus(1'h0, a, 32'h0);
    ck(hrdata, e);
  endtask
  task wrap_up(input integer t);
    bad_count += t;
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    rd(12'hF70, 32'h0);
    ck({31'h0, hresp}, 32'h0);
    bus(1'h1, 12'hF70, 32'hA3);
    rd(12'hF70, 32'hA3);
    ck({26'h0, pins}, 32'h13);
    wait_done;
    ck(last_len, 32'h14);
    rd(12'hF70, 32'h23);
    bus(1'h1, 12'hF78, 32'h1);
    rd(12'hF74, 32'h1);
    ck({31'h0, irq}, 32'h1);
    bus(1'h1, 12'hF74, 32'h3);
    rd(12'hF7C, 32'h0);
    ck({31'h0, irq}, 32'h0);
    bus(1'h1, 12'hF70, 32'h8F);
    bus(1'h1, 12'hF70, 32'h4F);
    rd(12'hF70, 32'hCF);
    ck({26'h0, pins}, 32'h2F);
    wait_done;
    ck(last_len, 32'h28);
    bus(1'h1, 12'hF70, 32'h80);
    bus(1'h1, 12'hF70, 32'h80);
    wait_done;
    ck(last_len, 32'h14);
    rd(12'hF74, 32'h3);
    bus(1'h1, 12'hF70, 32'h90);
    wait_done;
    ck(last_len, 32'h14);
    rd(12'hF70, 32'h90);
    bus(1'h1, 12'hF70, 32'h00);
    wait_done;
    ck(last_len, 32'h100);
    rd(12'hF70, 32'h0);
    ck(start_count, 32'h6);
    bus(1'h1, 12'hF70, 32'h85);
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    rd(12'hF70, 32'h0);
    rd(12'hF74, 32'h0);
    ck({31'h0, conv_busy}, 32'h0);
    wrap_up(0);
  end
endmodule // testbench
